// *** src/msvc_decoder.sv ***
/*
  mailbox service command decoder: the host fills a command message over
  apb, starts it, and reads back a single-frame response.
  assumes an apb master on CORE_CLK_I and the msvc_msgmem buffer.
*/
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "msvc_map.svh"
module msvc_decoder import msvc_pkg::*; #(
  parameter logic [47:0] DEFAULT_MAC = 48'h0200_0000_0001
) (
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic WEB_EN_O,
  output logic FTP_EN_O,
  output logic ADMIN_MODE_O,
  output logic VFS_HIDE_O,
  output logic [47:0] PORT_MAC_O,
  output logic CMD_BUSY_O
);
  msvc_mem_if #(.AW(6), .DW(16)) mbus();
  msvc_state_t state_q;
  logic [4:0] cnt_q;
  logic [4:0] prev_idx;
  msvc_word_t id_q, info_q, cmd_q, size_q, fcnt_q, fnum_q, offh_q, offl_q;
  msvc_word_t d_q [0:2];
  msvc_word_t rsp_word;
  logic web_q, ftp_q, admin_q, vfs_q, mac_set_q, done_q, err_q, rd_valid_q;
  logic [47:0] mac_q;
  logic busy, is_mem, is_reg, acc, rd_issue, mem_wr, go, cmd_ok, is_mac, known;

  msvc_msgmem #(.AW(6), .DW(16)) u_mem (
    .clk_i(CORE_CLK_I),
    .rst_i(SYS_RST_I),
    .port(mbus.mem)
  );

  // apb decode
  assign busy = (state_q != S_IDLE);
  assign is_mem = (PADDR_I < `MSVC_MEM_TOP);
  assign is_reg = (PADDR_I >= `MSVC_OFF_CTRL) && (PADDR_I <= `MSVC_OFF_MAC_LO);
  assign acc = PSEL_I && PENABLE_I;
  assign rd_issue = PSEL_I && !PWRITE_I && is_mem && !busy && !rd_valid_q;
  assign mem_wr = acc && PWRITE_I && is_mem && !busy && (&PSTRB_I[1:0]);
  assign go = acc && PWRITE_I && PADDR_I == `MSVC_OFF_CTRL && PSTRB_I[0]
    && PWDATA_I[`MSVC_CTRL_GO] && !busy;

  // buffer reads wait one cycle for the read data, and both reads and writes wait while a command runs
  always_comb begin
    if (!is_mem) begin
      PREADY_O = 1'b1;
    end else if (PWRITE_I) begin
      PREADY_O = !busy;
    end else begin
      PREADY_O = rd_valid_q;
    end
  end
  assign PSLVERR_O = acc && PREADY_O && !is_mem && !is_reg;

  // read of the buffer issued in the setup or a stalled access cycle
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_issue;
    end
  end

  // read data mux
  always_comb begin
    PRDATA_O = 32'h0000_0000;
    if (is_mem) begin
      PRDATA_O = {16'h0000, mbus.rdata};
    end else begin
      unique case (PADDR_I)
        `MSVC_OFF_STATUS: PRDATA_O = {29'h0, err_q, done_q, busy};
        `MSVC_OFF_CFG: PRDATA_O = {27'h0, mac_set_q, vfs_q, admin_q, ftp_q, web_q};
        `MSVC_OFF_MAC_HI: PRDATA_O = {16'h0000, mac_q[47:32]};
        `MSVC_OFF_MAC_MID: PRDATA_O = {16'h0000, mac_q[31:16]};
        `MSVC_OFF_MAC_LO: PRDATA_O = {16'h0000, mac_q[15:0]};
        default: PRDATA_O = 32'h0000_0000;
      endcase
    end
  end

  // buffer port ownership: engine while busy, apb otherwise
  assign mbus.raddr = busy ? {1'b0, cnt_q} : PADDR_I[7:2];
  assign mbus.we = (state_q == S_RESP) || mem_wr;
  assign mbus.waddr = busy ? {`MSVC_RSP_BASE, cnt_q} : PADDR_I[7:2];
  assign mbus.wdata = busy ? rsp_word : PWDATA_I[15:0];

  // sequencer
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_q <= S_IDLE;
      cnt_q <= 5'h00;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          cnt_q <= 5'h00;
          if (go) begin
            state_q <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (cnt_q == `MSVC_FETCH_END) begin
            state_q <= S_APPLY;
            cnt_q <= 5'h00;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        S_APPLY: state_q <= S_RESP;
        S_RESP: begin
          if (cnt_q == `MSVC_IDX_LAST) begin
            state_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
      endcase
    end
  end

  // capture header and payload words one cycle behind the read address
  assign prev_idx = cnt_q - 5'h01;
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      {id_q, info_q, cmd_q, size_q} <= '0;
      {fcnt_q, fnum_q, offh_q, offl_q} <= '0;
      d_q[0] <= 16'h0000;
      d_q[1] <= 16'h0000;
      d_q[2] <= 16'h0000;
    end else if (state_q == S_FETCH && cnt_q != 5'h00) begin
      unique case (prev_idx)
        `MSVC_IDX_ID: id_q <= mbus.rdata;
        `MSVC_IDX_INFO: info_q <= mbus.rdata;
        `MSVC_IDX_CMD: cmd_q <= mbus.rdata;
        `MSVC_IDX_SIZE: size_q <= mbus.rdata;
        `MSVC_IDX_FCNT: fcnt_q <= mbus.rdata;
        `MSVC_IDX_FNUM: fnum_q <= mbus.rdata;
        `MSVC_IDX_OFFH: offh_q <= mbus.rdata;
        `MSVC_IDX_OFFL: offl_q <= mbus.rdata;
        `MSVC_IDX_D0: d_q[0] <= mbus.rdata;
        `MSVC_IDX_D1: d_q[1] <= mbus.rdata;
        `MSVC_IDX_D2: d_q[2] <= mbus.rdata;
        default: ;
      endcase
    end
  end

  // command checks
  assign is_mac = (cmd_q == `MSVC_CMD_MAC_WR);
  assign known = is_mac || cmd_q == `MSVC_CMD_WEB_OFF || cmd_q == `MSVC_CMD_WEB_ON
    || cmd_q == `MSVC_CMD_FTP_OFF || cmd_q == `MSVC_CMD_ADMIN
    || cmd_q == `MSVC_CMD_VFS_HIDE;
  assign cmd_ok = known && info_q == `MSVC_INFO_CMD && fcnt_q == `MSVC_ONE_FRAME
    && fnum_q == `MSVC_ONE_FRAME && offh_q == 16'h0000 && offl_q == 16'h0000
    && size_q == (is_mac ? `MSVC_MAC_SIZE : 16'h0000);

  // service state, updated once per accepted command
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      web_q <= `MSVC_WEB_RST;
      ftp_q <= `MSVC_FTP_RST;
      admin_q <= `MSVC_ADMIN_RST;
      vfs_q <= `MSVC_VFS_RST;
      mac_set_q <= 1'b0;
    end else if (state_q == S_APPLY && cmd_ok) begin
      if (cmd_q == `MSVC_CMD_WEB_OFF) web_q <= 1'b0;
      if (cmd_q == `MSVC_CMD_WEB_ON) web_q <= 1'b1;
      if (cmd_q == `MSVC_CMD_FTP_OFF) ftp_q <= 1'b0;
      if (cmd_q == `MSVC_CMD_ADMIN) admin_q <= 1'b1;
      if (cmd_q == `MSVC_CMD_VFS_HIDE) vfs_q <= 1'b1;
      if (is_mac) mac_set_q <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      mac_q <= DEFAULT_MAC;
    end else if (state_q == S_APPLY && cmd_ok && is_mac) begin
      mac_q <= {d_q[0], d_q[1], d_q[2]};
    end
  end

  // completion and error flags; a new start clears them
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else if (go) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      if (state_q == S_APPLY) err_q <= !cmd_ok;
      if (state_q == S_RESP && cnt_q == `MSVC_IDX_LAST) done_q <= 1'b1;
    end
  end

  // response words
  always_comb begin
    rsp_word = 16'h0000;
    unique case (cnt_q)
      `MSVC_IDX_ID: rsp_word = id_q;
      `MSVC_IDX_INFO: rsp_word = `MSVC_INFO_RSP;
      `MSVC_IDX_CMD: rsp_word = cmd_q;
      `MSVC_IDX_SIZE: rsp_word = (is_mac && cmd_ok) ? `MSVC_MAC_SIZE : 16'h0000;
      `MSVC_IDX_FCNT: rsp_word = `MSVC_ONE_FRAME;
      `MSVC_IDX_FNUM: rsp_word = `MSVC_ONE_FRAME;
      `MSVC_IDX_D0: rsp_word = (is_mac && cmd_ok) ? d_q[0] : 16'h0000;
      `MSVC_IDX_D1: rsp_word = (is_mac && cmd_ok) ? d_q[1] : 16'h0000;
      `MSVC_IDX_D2: rsp_word = (is_mac && cmd_ok) ? d_q[2] : 16'h0000;
      default: rsp_word = 16'h0000;
    endcase
  end

  // outputs
  assign WEB_EN_O = web_q;
  assign FTP_EN_O = ftp_q;
  assign ADMIN_MODE_O = admin_q;
  assign VFS_HIDE_O = vfs_q;
  assign PORT_MAC_O = mac_q;
  assign CMD_BUSY_O = busy;

  // checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic ap;
  assign ap = (state_q == S_APPLY) && cmd_ok;
  logic rw;
  assign rw = (state_q == S_RESP);

  property p_web_off;
    ap && cmd_q == `MSVC_CMD_WEB_OFF |=> !WEB_EN_O [*2];
  endproperty
  a_web_off: assert property (p_web_off) else $error("web stays on");
  property p_web_on;
    ap && cmd_q == `MSVC_CMD_WEB_ON |=> WEB_EN_O;
  endproperty
  a_web_on: assert property (p_web_on) else $error("web stays off");
  property p_web_keep;
    $fell(WEB_EN_O) |-> $past(ap && cmd_q == `MSVC_CMD_WEB_OFF);
  endproperty
  a_web_keep: assert property (p_web_keep) else $error("web off without cmd");
  property p_ftp_off;
    ap && cmd_q == `MSVC_CMD_FTP_OFF |=> !FTP_EN_O;
  endproperty
  a_ftp_off: assert property (p_ftp_off) else $error("ftp stays on");
  property p_admin;
    $rose(ADMIN_MODE_O) |-> $past(ap && cmd_q == `MSVC_CMD_ADMIN);
  endproperty
  a_admin: assert property (p_admin) else $error("admin without cmd");
  property p_vfs;
    ap && cmd_q == `MSVC_CMD_VFS_HIDE |=> VFS_HIDE_O;
  endproperty
  a_vfs: assert property (p_vfs) else $error("files not hidden");
  property p_mac;
    ap && is_mac |=> PORT_MAC_O == {$past(d_q[0]), $past(d_q[1]), $past(d_q[2])};
  endproperty
  a_mac: assert property (p_mac) else $error("port address not taken");
  property p_size;
    rw && cnt_q == `MSVC_IDX_SIZE && ap == 1'b0 && is_mac && mac_set_q && !err_q
      |-> mbus.wdata == `MSVC_MAC_SIZE;
  endproperty
  a_size: assert property (p_size) else $error("bad answer size");
  property p_echo;
    rw && cnt_q == `MSVC_IDX_D0 && is_mac && !err_q |-> mbus.wdata == d_q[0];
  endproperty
  a_echo: assert property (p_echo) else $error("address not echoed");
  property p_info;
    $rose(rw) |-> ##1 mbus.wdata == `MSVC_INFO_RSP ##1 mbus.wdata == cmd_q;
  endproperty
  a_info: assert property (p_info) else $error("bad answer header");
  property p_frame;
    rw && cnt_q == `MSVC_IDX_FCNT |-> mbus.we && mbus.wdata == `MSVC_ONE_FRAME
      ##1 mbus.wdata == `MSVC_ONE_FRAME;
  endproperty
  a_frame: assert property (p_frame) else $error("not one frame");

  c_web: cover property (ap && cmd_q == `MSVC_CMD_WEB_OFF);
  c_mac: cover property (ap && is_mac);
  c_err: cover property (state_q == S_APPLY && !cmd_ok);
  c_rd: cover property (rd_valid_q && acc);
endmodule
`default_nettype wire

// *** shared/msvc_map.svh ***
/*
  constants of the mailbox service command decoder: message word indices,
  command numbers, apb offsets, status bits and reset values.
  assumes inclusion by the decoder design file under one guard.
*/
`ifndef MSVC_MAP_SVH
`define MSVC_MAP_SVH

// message information words
`define MSVC_INFO_CMD 16'h4002
`define MSVC_INFO_RSP 16'h0002
`define MSVC_ONE_FRAME 16'h0001
`define MSVC_MAC_SIZE 16'h0006

// command numbers
`define MSVC_CMD_WEB_OFF 16'h0004
`define MSVC_CMD_WEB_ON 16'h0005
`define MSVC_CMD_FTP_OFF 16'h0006
`define MSVC_CMD_ADMIN 16'h000b
`define MSVC_CMD_VFS_HIDE 16'h0011
`define MSVC_CMD_MAC_WR 16'h0123

// word indices inside one message
`define MSVC_IDX_ID 5'h00
`define MSVC_IDX_INFO 5'h01
`define MSVC_IDX_CMD 5'h02
`define MSVC_IDX_SIZE 5'h03
`define MSVC_IDX_FCNT 5'h04
`define MSVC_IDX_FNUM 5'h05
`define MSVC_IDX_OFFH 5'h06
`define MSVC_IDX_OFFL 5'h07
`define MSVC_IDX_D0 5'h10
`define MSVC_IDX_D1 5'h11
`define MSVC_IDX_D2 5'h12
`define MSVC_IDX_LAST 5'h12
`define MSVC_FETCH_END 5'h13

// buffer areas: command at words 0..31, response at 32..63
`define MSVC_RSP_BASE 1'b1

// apb register byte offsets
`define MSVC_OFF_CTRL 12'h100
`define MSVC_OFF_STATUS 12'h104
`define MSVC_OFF_CFG 12'h108
`define MSVC_OFF_MAC_HI 12'h10c
`define MSVC_OFF_MAC_MID 12'h110
`define MSVC_OFF_MAC_LO 12'h114
`define MSVC_MEM_TOP 12'h100

// field positions
`define MSVC_CTRL_GO 0
`define MSVC_ST_BUSY 0
`define MSVC_ST_DONE 1
`define MSVC_ST_ERR 2

// reset values
`define MSVC_WEB_RST 1'b1
`define MSVC_FTP_RST 1'b1
`define MSVC_ADMIN_RST 1'b0
`define MSVC_VFS_RST 1'b0

`endif

// *** shared/msvc_pkg.sv ***
/*
  types of the mailbox service command decoder.
  assumes msvc_map.svh beside it.
*/
package msvc_pkg;
  typedef logic [15:0] msvc_word_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_FETCH = 4'b0010,
    S_APPLY = 4'b0100,
    S_RESP = 4'b1000
  } msvc_state_t;
endpackage

// *** shared/msvc_mem_if.sv ***
/*
  one write port and one registered read port of the message buffer.
  assumes the decoder drives the ctrl side and the buffer the mem side.
*/
`timescale 1ns/1ps
`default_nettype none
interface msvc_mem_if #(parameter int AW = 6, parameter int DW = 16);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl(output we, output waddr, output wdata, output raddr, input rdata);
  modport mem(input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// *** src/msvc_msgmem.sv ***
/*
  message buffer: plain word memory with registered read data.
  assumes one clock and an active high asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module msvc_msgmem #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  msvc_mem_if.mem port
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // write port
  always_ff @(posedge clk_i) begin
    if (port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  // read data from a register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port.rdata <= '0;
    end else begin
      port.rdata <= mem_q[port.raddr];
    end
  end
endmodule
`default_nettype wire

// *** testbench/msvc_host_model.sv ***
/*
  host side model: apb master that builds single-frame command messages.
  assumes the decoder answers with PREADY and the clock runs free.
*/
`timescale 1ns/1ps
`default_nettype none
module msvc_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  output logic hang_o
);
  // idle bus at time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
    hang_o = 1'b0;
  end

  // one transfer; ready, read data and error are taken at the rising edge that ends it
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    n = 0;
    // no request while reset holds
    while (rst_i !== 1'b0 && n < 200) begin
      n++;
      @(posedge clk_i);
    end
    n = 0;
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1 && n < 200) begin
      n++;
      @(posedge clk_i);
    end
    q = prdata_i;
    err = pslverr_i;
    if (n >= 200) hang_o <= 1'b1;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
  endtask

  // fill the command area, start it, poll status until done
  task automatic send(input logic [15:0] info, input logic [15:0] cmd,
                      input logic [15:0] size, input logic [47:0] mac,
                      output logic [31:0] st0, output logic [31:0] stf);
    logic [15:0] w [0:18];
    int n;
    w = '{default: 16'h0000};
    w[0] = cmd ^ 16'h5a5a;
    w[1] = info;
    w[2] = cmd;
    w[3] = size;
    w[4] = 16'h0001;
    w[5] = 16'h0001;
    w[16] = mac[47:32];
    w[17] = mac[31:16];
    w[18] = mac[15:0];
    for (int i = 0; i < 19; i++) wr(12'(4 * i), {16'h0000, w[i]});
    wr(12'h100, 32'h1);
    rd(12'h104, st0);
    stf = st0;
    n = 0;
    while (stf[1] !== 1'b1 && n < 100) begin
      n++;
      rd(12'h104, stf);
    end
    if (n >= 100) hang_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** testbench/mailbox_service_command_decoder_tb_top.sv ***
/*
  testbench of the mailbox service command decoder.
  assumes msvc_decoder with its buffer inside and the apb host model.
*/
`timescale 1ns/1ps
`default_nettype none
module mailbox_service_command_decoder_tb_top;
  localparam logic [47:0] DEF_MAC = 48'h0a0b_0c0d_0e0f;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, hang;
  logic web, ftp, adm, vfs, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [47:0] mac;
  int n_mismatch, num_checks;

  msvc_host_model i_host (.clk_i(clk), .rst_i(rst), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr), .hang_o(hang));

  msvc_decoder #(.DEFAULT_MAC(DEF_MAC)) i_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .WEB_EN_O(web), .FTP_EN_O(ftp), .ADMIN_MODE_O(adm),
    .VFS_HIDE_O(vfs), .PORT_MAC_O(mac), .CMD_BUSY_O(busy));

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // header of a response, then echoed address words when size is six
  task automatic chk_rsp(input logic [15:0] cmd, input logic [15:0] size,
                         input logic [47:0] a);
    logic [15:0] e [0:7];
    logic [31:0] q;
    e = '{cmd ^ 16'h5a5a, 16'h0002, cmd, size, 16'h0001, 16'h0001, 16'h0000, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      i_host.rd(12'(12'h080 + 4 * i), q);
      chk("rsp word", 48'(q), 48'(e[i]));
    end
    for (int i = 0; i < 3 && size == 16'h0006; i++) begin
      i_host.rd(12'(12'h0c0 + 4 * i), q);
      chk("rsp data", 48'(q), 48'(a[47 - 16 * i -: 16]));
    end
  endtask

  task automatic t_reset();
    logic [31:0] q;
    chk("web", 48'(web), 48'h1);
    chk("ftp adm vfs busy", 48'({ftp, adm, vfs, busy}), 48'h8);
    chk("mac", mac, DEF_MAC);
    i_host.rd(12'h108, q);
    chk("cfg", 48'(q), 48'h3);
  endtask

  // every empty command in turn, flags tracked as {vfs, adm, ftp, web}
  task automatic t_plain();
    logic [15:0] cmds [0:4];
    logic [3:0] f;
    logic [31:0] s0, sf;
    cmds = '{16'h0004, 16'h0006, 16'h000b, 16'h0011, 16'h0005};
    f = 4'b0011;
    for (int k = 0; k < 5; k++) begin
      i_host.send(16'h4002, cmds[k], 16'h0000, 48'h0, s0, sf);
      case (cmds[k])
        16'h0004: f[0] = 1'b0;
        16'h0006: f[1] = 1'b0;
        16'h000b: f[2] = 1'b1;
        16'h0011: f[3] = 1'b1;
        default: f[0] = 1'b1;
      endcase
      chk("flags", 48'({vfs, adm, ftp, web}), 48'(f));
      chk("busy after go", 48'(s0[0]), 48'h1);
      chk("status", 48'(sf[2:0]), 48'h2);
      chk_rsp(cmds[k], 16'h0000, 48'h0);
    end
  endtask

  // custom address accepted, echoed and put in use
  task automatic t_mac();
    logic [31:0] s0, sf, q;
    i_host.send(16'h4002, 16'h0123, 16'h0006, 48'ha1b2_c3d4_e5f6, s0, sf);
    chk("status", 48'(sf[2:0]), 48'h2);
    chk_rsp(16'h0123, 16'h0006, 48'ha1b2_c3d4_e5f6);
    chk("mac", mac, 48'ha1b2_c3d4_e5f6);
    i_host.rd(12'h10c, q);
    chk("mac hi", 48'(q), 48'ha1b2);
    i_host.rd(12'h110, q);
    chk("mac mid", 48'(q), 48'hc3d4);
    i_host.rd(12'h114, q);
    chk("mac lo", 48'(q), 48'he5f6);
    i_host.rd(12'h108, q);
    chk("cfg", 48'(q), 48'h1d);
  endtask

  // bad info, bad size, unknown number, unmapped and read-only places
  task automatic t_reject();
    logic [31:0] s0, sf, q;
    logic e;
    i_host.send(16'h4001, 16'h0004, 16'h0000, 48'h0, s0, sf);
    chk("bad info", 48'({sf[2:0], web}), 48'hd);
    i_host.send(16'h4002, 16'h0123, 16'h0004, 48'h1111_2222_3333, s0, sf);
    chk("bad size", 48'(sf[2:0]), 48'h6);
    chk("mac kept", mac, 48'ha1b2_c3d4_e5f6);
    i_host.rd(12'h08c, q);
    chk("rsp size", 48'(q), 48'h0);
    i_host.send(16'h4002, 16'h0007, 16'h0000, 48'h0, s0, sf);
    chk("unknown", 48'(sf[2:0]), 48'h6);
    // partial strobes leave the id word alone
    pstrb <= 4'hc;
    i_host.wr(12'h000, 32'h0000_beef);
    pstrb <= 4'hf;
    i_host.rd(12'h000, q);
    chk("strobe", 48'(q), 48'h5a5d);
    i_host.xfer(1'b0, 12'h200, 32'h0, q, e);
    chk("unmapped", 48'(e), 48'h1);
    i_host.wr(12'h108, 32'h0);
    i_host.rd(12'h108, q);
    chk("cfg ro", 48'(q), 48'h1d);
  endtask

  // a stuck handshake ends the run
  always @(posedge hang) begin
    n_mismatch++;
    summarize();
  end

  // reset, then the plain commands, the custom address and the rejected accesses
  initial begin
    rst = 1'b1;
    pstrb = 4'hf;
    n_mismatch = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_plain();
    t_mac();
    t_reject();
    // a second reset brings the defaults back
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
